// *** verilog/pdtx_cfg.svh ***
/*
  Constants of the transmit status and header parameter block:
  register indices, field positions, reset values, encodings.
  Assumes inclusion by bare name from the modules; the package does not include it.
*/
`ifndef PDTX_CFG_SVH
`define PDTX_CFG_SVH

// register indices; byte address is four times the index
`define PDTX_IDX_STAT 16'h1A01
`define PDTX_IDX_PARAM 16'h1A02
`define PDTX_IDX_CTRL 16'h1A20
`define PDTX_IDX_IRQST 16'h1A21
`define PDTX_IDX_IRQMSK 16'h1A22

// status register fields
`define PDTX_ST_ACTIVE 0
`define PDTX_RETRY_LSB 4
`define PDTX_RETRY_MSB 6

// parameter register fields
`define PDTX_PAR_DROLE 7
`define PDTX_PAR_PROLE 2
`define PDTX_PAR_CABLE 3
`define PDTX_PAR_WMASK 8'hFC
`define PDTX_PAR_RST 8'h00

// control register fields
`define PDTX_CT_GO 0
`define PDTX_CT_ABORT 1
`define PDTX_CT_AUTO 2
`define PDTX_CT_AWAIT 3
`define PDTX_SOP_LSB 4
`define PDTX_SOP_MSB 6
`define PDTX_CT_RST 8'h00

// frame kinds in the control register
`define PDTX_SOP_PLAIN 3'h0
`define PDTX_SOP_PRIME 3'h1
`define PDTX_SOP_DPRIME 3'h2
`define PDTX_SOP_HARDRST 3'h5
`define PDTX_SOP_CABLERST 3'h6

// interrupt status bits
`define PDTX_IRQ_DONE 0
`define PDTX_IRQ_FAIL 1
`define PDTX_IRQ_ABORT 2
`define PDTX_IRQ_W 3

`endif

// *** verilog/pdtx_pkg.sv ***
/*
  Types of the transmit status and header parameter block.
  Assumes pdtx_cfg.svh is on the include path.
*/
package pdtx_pkg;

  // header bits handed to the header generator
  typedef struct packed {
    logic dataRole;
    logic powerRole;
    logic cablePlug;
  } pdtx_hdr_t;

  // one-cycle events from the framer, same clock
  typedef struct packed {
    logic sent;
    logic ackGood;
    logic ackMiss;
    logic linkAbort;
  } pdtx_evt_t;

  typedef enum logic [2:0] {
    PDTX_IDLE = 3'h1,
    PDTX_SEND = 3'h2,
    PDTX_WAIT = 3'h4
  } pdtx_state_t;

endpackage : pdtx_pkg

// *** verilog/pdtx_wb_slave.sv ***
/*
  Classic Wishbone slave front end: one-cycle ack, registered
  read data, word index decode and access strobes.
  Assumes the register file answers readData combinationally.
*/
`timescale 1ns/1ps
module pdtx_wb_slave (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] readData,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic [15:0] regIdx,
  output logic wrStb,
  output logic rdStb
);
  logic take;

  // request taken only when not already acking it
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign regIdx = {2'h0, wb_adr_i[15:2]};
  assign wrStb = take & wb_we_i & wb_sel_i[0];
  assign rdStb = take & ~wb_we_i;

  // ack one cycle after the request, dropped the next
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= take;
    end
  end

  // narrow registers sit in the low byte, upper bits zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rdStb) begin
      wb_dat_o <= {24'h00_0000, readData};
    end
  end
endmodule : pdtx_wb_slave

// *** verilog/pdtx_irq.sv ***
/*
  Sticky event flags, mask and the level interrupt output.
  Assumes clrRead pulses once for each read of the status.
*/
`timescale 1ns/1ps
module pdtx_irq #(
  parameter int W = 3
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] evt,
  input wire logic clrRead,
  input wire logic [W-1:0] mask,
  output logic [W-1:0] flags,
  output logic irq
);
  genvar i;

  // an event in the clearing cycle survives the read
  generate
    for (i = 0; i < W; i++) begin : g_flag
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          flags[i] <= 1'b0;
        end else if (evt[i]) begin
          flags[i] <= 1'b1;
        end else if (clrRead) begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // registered level, one cycle behind the flags
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & mask);
    end
  end
endmodule : pdtx_irq

// *** verilog/pdtx_status_params.sv ***
/*
  Transmit status and header parameter logic of a PD MAC:
  retry counting, transmitter activity, retry sequencing and
  the role bits placed into hardware generated headers.
  Assumes a framer on core_clk that starts an attempt on
  attemptStart and reports sent, GoodCRC and missing GoodCRC
  as one-cycle pulses; software uses classic Wishbone.
*/
// Overview of operation
// - launch clears the retry count
// - count is zero or retries done
// - count never exceeds programmed retry limit
// - status bit zero shows transmitter active
// - active falls whenever transmitting stops
// - SOP header data role from bit seven
// - primed SOP headers carry zero data role
// - zero retry limit disables hardware retry
// - no wait for ack unless asked or hardware retry is on
// - hard and cable reset never retried
// - primed SOP headers carry cable plug bit
// - SOP header power role from bit two
// - auto response off means no retries
// - await option waits for GoodCRC on every frame kind except hard and cable reset
`timescale 1ns/1ps
`include "pdtx_cfg.svh"
module pdtx_status_params (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire pdtx_pkg::pdtx_evt_t framerEvt,
  output pdtx_pkg::pdtx_hdr_t hdrBits,
  output logic [2:0] frameKind,
  output logic attemptStart,
  output logic attemptAbort,
  output logic txActive,
  output logic irq
);
  import pdtx_pkg::*;

  // register contents
  logic [7:0] txParams;
  logic [2:0] retriesUsedCount;
  logic autoResponseEnable;
  logic awaitAckOption;
  logic [2:0] sopKind;
  logic [`PDTX_IRQ_W-1:0] irqMask;

  // bus side
  logic [15:0] regIdx;
  logic wrStb;
  logic rdStb;
  logic [7:0] readData;
  logic [7:0] wByte;

  // sequencer
  pdtx_state_t state;
  pdtx_state_t next_state;
  logic [2:0] allowedRetryLimit;
  logic goPulse;
  logic abortPulse;
  logic isResetSig;
  logic retryOn;
  logic needAck;
  logic canRetry;
  logic doRetry;
  logic finOk;
  logic finFail;
  logic finAbort;
  logic [`PDTX_IRQ_W-1:0] irqEvt;
  logic [`PDTX_IRQ_W-1:0] irqFlags;
  logic irqRead;

  assign wByte = wb_dat_i[7:0];

  pdtx_wb_slave u_bus (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .readData(readData),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .regIdx(regIdx),
    .wrStb(wrStb),
    .rdStb(rdStb)
  );

  // write strobes of the control register bits
  assign goPulse = wrStb & (regIdx == `PDTX_IDX_CTRL)
    & wByte[`PDTX_CT_GO];
  assign abortPulse = wrStb & (regIdx == `PDTX_IDX_CTRL)
    & wByte[`PDTX_CT_ABORT];

  // parameter register; reserved low bits never stored
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      txParams <= `PDTX_PAR_RST;
    end else if (wrStb && regIdx == `PDTX_IDX_PARAM) begin
      txParams <= wByte & `PDTX_PAR_WMASK;
    end
  end

  assign allowedRetryLimit =
    txParams[`PDTX_RETRY_MSB:`PDTX_RETRY_LSB];

  // control options; frame kind frozen while active so the
  // frame kind in the header bits cannot change under a packet
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      autoResponseEnable <= 1'b0;
      awaitAckOption <= 1'b0;
      sopKind <= `PDTX_SOP_PLAIN;
    end else if (wrStb && regIdx == `PDTX_IDX_CTRL) begin
      autoResponseEnable <= wByte[`PDTX_CT_AUTO];
      awaitAckOption <= wByte[`PDTX_CT_AWAIT];
      if (!txActive) begin
        sopKind <= wByte[`PDTX_SOP_MSB:`PDTX_SOP_LSB];
      end
    end
  end

  // interrupt mask
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irqMask <= '0;
    end else if (wrStb && regIdx == `PDTX_IDX_IRQMSK) begin
      irqMask <= wByte[`PDTX_IRQ_W-1:0];
    end
  end

  // retry policy
  assign isResetSig = (sopKind == `PDTX_SOP_HARDRST)
    | (sopKind == `PDTX_SOP_CABLERST);
  // retries only with auto response and a nonzero limit
  assign retryOn = autoResponseEnable
    & (allowedRetryLimit != 3'h0);
  // resets get no ack, so they never wait for one
  assign needAck = ~isResetSig
    & (retryOn | awaitAckOption);
  assign canRetry = retryOn & ~isResetSig
    & (retriesUsedCount < allowedRetryLimit);
  assign doRetry = (state == PDTX_WAIT) & framerEvt.ackMiss
    & canRetry;

  // state transition
  always_comb begin
    next_state = state;
    finOk = 1'b0;
    finFail = 1'b0;
    finAbort = 1'b0;
    case (state)
      PDTX_IDLE: begin
        if (goPulse) begin
          next_state = PDTX_SEND;
        end
      end
      PDTX_SEND: begin
        if (abortPulse || framerEvt.linkAbort) begin
          next_state = PDTX_IDLE;
          finAbort = 1'b1;
        end else if (framerEvt.sent) begin
          if (needAck) begin
            next_state = PDTX_WAIT;
          end else begin
            next_state = PDTX_IDLE;
            finOk = 1'b1;
          end
        end
      end
      PDTX_WAIT: begin
        if (abortPulse || framerEvt.linkAbort) begin
          next_state = PDTX_IDLE;
          finAbort = 1'b1;
        end else if (framerEvt.ackGood) begin
          next_state = PDTX_IDLE;
          finOk = 1'b1;
        end else if (framerEvt.ackMiss) begin
          if (canRetry) begin
            next_state = PDTX_SEND;
          end else begin
            next_state = PDTX_IDLE;
            finFail = 1'b1;
          end
        end
      end
      default: begin
        next_state = PDTX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= PDTX_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // retry count; stale after an abort, software ignores it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      retriesUsedCount <= 3'h0;
    end else if (goPulse && state == PDTX_IDLE) begin
      retriesUsedCount <= 3'h0;
    end else if (doRetry) begin
      retriesUsedCount <= retriesUsedCount + 3'h1;
    end
  end

  // active flag follows any exit to idle, good or bad
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      txActive <= 1'b0;
    end else begin
      txActive <= (next_state != PDTX_IDLE);
    end
  end

  // attempt launch pulse, first try and each retry
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      attemptStart <= 1'b0;
      attemptAbort <= 1'b0;
    end else begin
      attemptStart <= (goPulse && state == PDTX_IDLE) | doRetry;
      attemptAbort <= finAbort;
    end
  end

  // header bits by frame kind
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hdrBits <= '0;
      frameKind <= `PDTX_SOP_PLAIN;
    end else begin
      frameKind <= sopKind;
      if (sopKind == `PDTX_SOP_PLAIN) begin
        hdrBits.dataRole <= txParams[`PDTX_PAR_DROLE];
        hdrBits.powerRole <= txParams[`PDTX_PAR_PROLE];
        hdrBits.cablePlug <= 1'b0;
      end else begin
        hdrBits.dataRole <= 1'b0;
        hdrBits.powerRole <= 1'b0;
        hdrBits.cablePlug <= (sopKind == `PDTX_SOP_PRIME
          || sopKind == `PDTX_SOP_DPRIME)
          & txParams[`PDTX_PAR_CABLE];
      end
    end
  end

  // interrupt events
  assign irqEvt[`PDTX_IRQ_DONE] = finOk;
  assign irqEvt[`PDTX_IRQ_FAIL] = finFail;
  assign irqEvt[`PDTX_IRQ_ABORT] = finAbort;
  assign irqRead = rdStb & (regIdx == `PDTX_IDX_IRQST);

  pdtx_irq #(
    .W(`PDTX_IRQ_W)
  ) u_irq (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .evt(irqEvt),
    .clrRead(irqRead),
    .mask(irqMask),
    .flags(irqFlags),
    .irq(irq)
  );

  // read mux; reserved and unmapped bits read zero
  always_comb begin
    readData = 8'h00;
    case (regIdx)
      `PDTX_IDX_STAT: begin
        readData[`PDTX_RETRY_MSB:`PDTX_RETRY_LSB] =
          retriesUsedCount;
        readData[`PDTX_ST_ACTIVE] = txActive;
      end
      `PDTX_IDX_PARAM: begin
        readData = txParams;
      end
      `PDTX_IDX_CTRL: begin
        readData[`PDTX_CT_AUTO] = autoResponseEnable;
        readData[`PDTX_CT_AWAIT] = awaitAckOption;
        readData[`PDTX_SOP_MSB:`PDTX_SOP_LSB] = sopKind;
      end
      `PDTX_IDX_IRQST: begin
        readData[`PDTX_IRQ_W-1:0] = irqFlags;
      end
      `PDTX_IDX_IRQMSK: begin
        readData[`PDTX_IRQ_W-1:0] = irqMask;
      end
      default: begin
        readData = 8'h00;
      end
    endcase
  end

endmodule : pdtx_status_params

// *** verif/pdtx_status_params_asserts.sv ***
/* Port assertions of pdtx_status_params.
   Assumes a bind from the bench; register writes are snooped. */
`timescale 1ns/1ps
`include "pdtx_cfg.svh"
module pdtx_status_params_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire pdtx_pkg::pdtx_evt_t framerEvt,
  input wire pdtx_pkg::pdtx_hdr_t hdrBits,
  input wire logic [2:0] frameKind,
  input wire logic attemptStart,
  input wire logic attemptAbort,
  input wire logic txActive,
  input wire logic irq
);
  import pdtx_pkg::*;
  logic [7:0] par;
  logic aut, awt, was, wr, resetKind, need, retry;
  logic [2:0] rt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // writes land at the ack edge while the master still holds them
  assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  assign resetKind = frameKind == `PDTX_SOP_HARDRST ||
    frameKind == `PDTX_SOP_CABLERST;
  assign need = !resetKind && ((aut && par[6:4] != 3'h0) || awt);
  assign retry = attemptStart && was;
  // shadow of the parameter and control bits
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      par <= 8'h00;
      aut <= 1'b0;
      awt <= 1'b0;
    end else if (wr && wb_adr_i == (`PDTX_IDX_PARAM << 2)) begin
      par <= wb_dat_i[7:0];
    end else if (wr && wb_adr_i == (`PDTX_IDX_CTRL << 2)) begin
      aut <= wb_dat_i[`PDTX_CT_AUTO];
      awt <= wb_dat_i[`PDTX_CT_AWAIT];
    end
  end
  // retries of the current message; a start from idle restarts it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      was <= 1'b0;
      rt <= 3'h0;
    end else begin
      was <= txActive;
      if (attemptStart && !was) rt <= 3'h0;
      else if (retry) rt <= rt + 3'h1;
    end
  end
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request not acked");
  a_rd_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_start_act: assert property (attemptStart |-> txActive)
    else $error("attempt while idle flag");
  a_retry_cap: assert property (retry |-> rt < par[6:4])
    else $error("retry beyond limit");
  a_retry_enable: assert property (retry |-> aut && par[6:4] != 3'h0)
    else $error("retry while disabled");
  a_reset_once: assert property (retry |-> !resetKind)
    else $error("reset signalling retried");
  a_no_wait: assert property (framerEvt.sent && txActive && !need &&
    !framerEvt.linkAbort |=> !txActive) else $error("waited for ack");
  a_ack_wait: assert property (framerEvt.sent && txActive && need &&
    !framerEvt.linkAbort |=> txActive) else $error("did not wait");
  a_sop_hdr: assert property ((txActive [*3]) ##0
    (frameKind == `PDTX_SOP_PLAIN) |-> hdrBits == {par[7], par[2], 1'b0})
    else $error("plain header bits wrong");
  a_prime_hdr: assert property ((txActive [*3]) ##0
    (frameKind inside {`PDTX_SOP_PRIME, `PDTX_SOP_DPRIME})
    |-> hdrBits == {2'b00, par[3]}) else $error("primed header wrong");
endmodule : pdtx_status_params_asserts

// *** verif/pdtx_framer_model.sv ***
/* Behavioural framer: answers every attempt start.
   Assumes the bench sets delay, ack use and miss count. */
`timescale 1ns/1ps
module pdtx_framer_model (
  input wire logic core_clk,
  input wire logic attemptStart,
  input wire logic txActive,
  input wire logic [3:0] dly,
  input wire logic ackOn,
  input wire logic [2:0] misses,
  output pdtx_pkg::pdtx_evt_t framerEvt
);
  import pdtx_pkg::*;
  int used;
  // sent first, then the answer; misses counted per message
  initial begin
    framerEvt = '0;
    used = 0;
    forever begin
      @(posedge core_clk);
      if (!txActive) used = 0;
      if (attemptStart) begin
        repeat (dly) @(posedge core_clk);
        framerEvt <= 4'h8;
        @(posedge core_clk);
        framerEvt <= '0;
        if (ackOn) begin
          repeat (dly) @(posedge core_clk);
          framerEvt <= (used < misses) ? 4'h2 : 4'h4;
          used++;
          @(posedge core_clk);
          framerEvt <= '0;
        end
      end
    end
  end
endmodule : pdtx_framer_model

// *** verif/pdtx_status_params_tb.sv ***
/* Self-checking bench of pdtx_status_params with a framer model.
   Assumes the checker and the model are compiled first. */
`timescale 1ns/1ps
`include "pdtx_cfg.svh"
`define CHK(nm, e, v) begin \
  totalChecks++; \
  if ((v) !== (e)) begin \
    badCount++; \
    $display("mismatch %s exp %0h got %0h", nm, e, v); \
  end \
end
module pdtx_status_params_tb;
  import pdtx_pkg::*;
  logic core_clk, rst_n, cyc, stb, we, ack, ackOn, irq;
  logic attemptStart, attemptAbort, txActive;
  logic [15:0] adr;
  logic [31:0] dat, rdat;
  logic [3:0] dly;
  logic [2:0] misses, kind;
  logic [7:0] q;
  pdtx_evt_t evt;
  pdtx_hdr_t hdr;
  int badCount, totalChecks, aborts;
  pdtx_status_params uut (.core_clk, .rst_n, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat), .framerEvt(evt),
    .hdrBits(hdr), .frameKind(kind), .attemptStart, .attemptAbort,
    .txActive, .irq);
  pdtx_framer_model fm (.core_clk, .attemptStart, .txActive, .dly,
    .ackOn, .misses, .framerEvt(evt));
  always #5 core_clk = ~core_clk;
  // abort pulses counted to prove a single-cycle pulse
  always @(posedge core_clk) if (attemptAbort === 1'b1) aborts++;
  task results;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task stuck;
    badCount++;
    results;
  endtask : stuck
  // classic cycle: hold everything until ack is sampled
  task automatic bus(input logic w, input logic [15:0] idx,
      input logic [7:0] d);
    int n;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= idx << 2;
    dat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) stuck;
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic go(input logic [2:0] k, input logic au, input logic aw);
    bus(1'b1, `PDTX_IDX_CTRL, {1'b0, k, aw, au, 2'b01});
  endtask : go
  task automatic waitIdle;
    int n;
    n = 0;
    while (txActive !== 1'b0 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    if (txActive !== 1'b0) stuck;
  endtask : waitIdle
  task regs;
    bus(1'b0, `PDTX_IDX_PARAM, 8'h00);
    `CHK("param reset", 8'h00, q)
    bus(1'b1, `PDTX_IDX_PARAM, 8'hFF);
    bus(1'b0, `PDTX_IDX_PARAM, 8'h00);
    `CHK("param", 8'hFC, q)
    bus(1'b1, `PDTX_IDX_STAT, 8'hFF);
    bus(1'b0, `PDTX_IDX_STAT, 8'h00);
    `CHK("status", 8'h00, q)
    bus(1'b1, 16'h0100, 8'hFF);
    bus(1'b0, 16'h0100, 8'h00);
    `CHK("unmapped", 8'h00, q)
  endtask : regs
  task plain;
    bus(1'b1, `PDTX_IDX_IRQMSK, 8'h00);
    bus(1'b1, `PDTX_IDX_PARAM, 8'h84);
    go(`PDTX_SOP_PLAIN, 1'b0, 1'b0);
    bus(1'b0, `PDTX_IDX_STAT, 8'h00);
    `CHK("active", 8'h01, q)
    `CHK("sop header", 3'b110, hdr)
    waitIdle;
    repeat (3) @(posedge core_clk);
    `CHK("masked irq", 1'b0, irq)
    bus(1'b1, `PDTX_IDX_IRQMSK, 8'h07);
    repeat (2) @(posedge core_clk);
    `CHK("irq", 1'b1, irq)
    bus(1'b0, `PDTX_IDX_IRQST, 8'h00);
    `CHK("done", 8'h01, q)
    repeat (2) @(posedge core_clk);
    `CHK("irq cleared", 1'b0, irq)
    bus(1'b0, `PDTX_IDX_STAT, 8'h00);
    `CHK("idle", 8'h00, q)
  endtask : plain
  task retries;
    bus(1'b1, `PDTX_IDX_PARAM, 8'hB8);
    ackOn <= 1'b1;
    misses <= 3'h2;
    go(`PDTX_SOP_PRIME, 1'b1, 1'b0);
    bus(1'b0, `PDTX_IDX_STAT, 8'h00);
    `CHK("prime header", 3'b001, hdr)
    `CHK("frame kind", `PDTX_SOP_PRIME, kind)
    waitIdle;
    bus(1'b0, `PDTX_IDX_IRQST, 8'h00);
    `CHK("ok", 8'h01, q)
    bus(1'b0, `PDTX_IDX_STAT, 8'h00);
    `CHK("count", 8'h20, q)
    misses <= 3'h5;
    go(`PDTX_SOP_DPRIME, 1'b1, 1'b0);
    waitIdle;
    bus(1'b0, `PDTX_IDX_IRQST, 8'h00);
    `CHK("failed", 8'h02, q)
    misses <= 3'h0;
    dly <= 4'h8;
    go(`PDTX_SOP_PLAIN, 1'b1, 1'b0);
    bus(1'b0, `PDTX_IDX_STAT, 8'h00);
    `CHK("cleared", 8'h01, q)
    waitIdle;
    bus(1'b0, `PDTX_IDX_STAT, 8'h00);
    `CHK("first ok", 8'h00, q)
    // drain the done flag so later scenarios see only their own
    bus(1'b0, `PDTX_IDX_IRQST, 8'h00);
    `CHK("ok again", 8'h01, q)
  endtask : retries
  task noAuto;
    misses <= 3'h1;
    dly <= 4'h3;
    go(`PDTX_SOP_PLAIN, 1'b0, 1'b1);
    waitIdle;
    bus(1'b0, `PDTX_IDX_IRQST, 8'h00);
    `CHK("no retry", 8'h02, q)
    bus(1'b1, `PDTX_IDX_PARAM, 8'h00);
    ackOn <= 1'b0;
    go(`PDTX_SOP_PLAIN, 1'b1, 1'b0);
    waitIdle;
    bus(1'b0, `PDTX_IDX_IRQST, 8'h00);
    `CHK("zero limit", 8'h01, q)
  endtask : noAuto
  task automatic resets;
    logic [2:0] rk [2] = '{`PDTX_SOP_HARDRST, `PDTX_SOP_CABLERST};
    bus(1'b1, `PDTX_IDX_PARAM, 8'h30);
    // a late miss would trip a wrongly retried reset
    ackOn <= 1'b1;
    foreach (rk[i]) begin
      go(rk[i], 1'b1, 1'b1);
      waitIdle;
      bus(1'b0, `PDTX_IDX_IRQST, 8'h00);
      `CHK("reset kind", 8'h01, q)
    end
  endtask : resets
  task abortTx;
    ackOn <= 1'b1;
    dly <= 4'hF;
    aborts = 0;
    go(`PDTX_SOP_PLAIN, 1'b1, 1'b0);
    bus(1'b1, `PDTX_IDX_CTRL, 8'h02);
    waitIdle;
    bus(1'b0, `PDTX_IDX_IRQST, 8'h00);
    `CHK("aborted", 8'h04, q)
    `CHK("abort pulses", 1, aborts)
  endtask : abortTx
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 16'h0000;
    dat = 32'h00000000;
    ackOn = 1'b0;
    dly = 4'h8;
    misses = 3'h0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    regs;
    plain;
    retries;
    noAuto;
    resets;
    abortTx;
    results;
  end
endmodule : pdtx_status_params_tb
bind pdtx_status_params pdtx_status_params_asserts chk (.core_clk,
  .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .wb_dat_o, .framerEvt, .hdrBits, .frameKind,
  .attemptStart, .attemptAbort, .txActive, .irq);
